// [dvid_consts.vh]
// constants for the dynamic voltage-code reference control
// assumes a 40 MHz system clock and a phase clock of several hundred kHz
`ifndef DVID_CONSTS_VH
`define DVID_CONSTS_VH
// code modes on the mode input
`define MODE_SIX 2'h0
`define MODE_FIVE 2'h1
`define MODE_ALT_FIVE 2'h2
// reads per switching cycle and reads needed for a valid code
`define SAMPLES_PER_CYCLE 3'h6
`define MATCH_NEEDED 2'h3
// reference count width, units of 12.5 mV
`define REF_W 7
`define REF_RESET 7'h00
// switching cycles between a no-load code and shutdown
`define NOLOAD_CYCLES 2'h2
// width of the phase-period measuring counter
`define PER_W 12
`define PER_RESET 12'h000
`endif

// [code_sampler.v]
// six-bit code mode validator: a code counts once it reads alike three times
// assumes sampleTick pulses six times per switching cycle
`timescale 1ns/10ps
`include "dvid_consts.vh"
module code_sampler (
  input wire clock,
  input wire nrst,
  input wire sampleTick,
  input wire [5:0] codeIn,
  output reg [5:0] validCode_q,
  output reg validPulse_q
);
  reg [5:0] lastCode_q;
  reg [1:0] matchCnt_q;
  always @(posedge clock) begin
    if (!nrst) begin
      lastCode_q <= 6'h3f;
      matchCnt_q <= 2'h0;
      validCode_q <= 6'h3f;
      validPulse_q <= 1'b0;
    end else begin
      validPulse_q <= 1'b0;
      if (sampleTick) begin
        lastCode_q <= codeIn;
        if (codeIn != lastCode_q) begin
          matchCnt_q <= 2'h1;
        end else if (matchCnt_q != `MATCH_NEEDED) begin
          matchCnt_q <= matchCnt_q + 2'h1;
          if (matchCnt_q + 2'h1 == `MATCH_NEEDED && codeIn != validCode_q) begin
            validCode_q <= codeIn;
            validPulse_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule // code_sampler

// [dynamic_vid_reference_control.v]
// dynamic voltage-code reference control: tracks the code inputs and moves the dac target
// assumes phaseClk is a synchronous level toggling at the switching rate, and codes are stable
// between processor transitions
//
// Functional notes
// - six-bit mode samples code inputs six times per switching cycle, evenly spaced.
// - six-bit mode accepts a new code after three identical consecutive samples.
// - six-bit mode loads the validated code into the reference immediately.
// - five-bit modes accept new codes differing by any number of steps.
// - five-bit modes wait half a phase cycle, then step once per cycle.
// - five-bit code change may take up to one switching cycle to notice.
// - codes 11111x in six-bit mode and x11111 in five-bit modes mean no load and shut down; others start soft-start.
// - after a no-load code wait two cycles, then raise trip level, stop pulses.
`timescale 1ns/10ps
`include "dvid_consts.vh"
module dynamic_vid_reference_control (
  input wire clock,
  input wire nrst,
  input wire phaseClk,
  input wire [1:0] codeMode,
  input wire [5:0] voltageCodeInputs,
  output reg [6:0] refTarget_q,
  output reg shutdownTrip_q,
  output reg pulseEnable_q,
  output reg softStartReq_q
);
  // ==========================================
  // code to reference count conversion
  // six-bit: count of 12.5 mV steps above 0.8375 V, so code 0x14 -> 0
  function [6:0] sixToCount;
    input [5:0] c;
    reg [5:0] m;
    begin
      m = {c[5] ^ 1'b1, c[4:1] ^ 4'hf, c[0] ^ 1'b1};
      // codes above 1.0875 V wrap past the two no-load codes, so skip them
      if (m >= 6'h2b)
        sixToCount = {1'b0, m - 6'h2b};
      else
        sixToCount = {1'b0, m} + 7'h13;
    end
  endfunction
  // five-bit: 25 mV steps; base 1.100 V (code 11110) counted from 0.8375 V
  function [6:0] fiveToCount;
    input [4:0] c;
    reg [4:0] m;
    begin
      m = {c[4] ^ 1'b1, c[3:0] ^ 4'hf};
      fiveToCount = {1'b0, m, 1'b0} + 7'h13;
    end
  endfunction
  function isNoLoad;
    input [1:0] md;
    input [5:0] c;
    begin
      if (md == `MODE_SIX)
        isNoLoad = (c[5:1] == 5'h1f);
      else
        isNoLoad = (c[4:0] == 5'h1f);
    end
  endfunction
  // ==========================================
  // phase period measurement, gives sample and half-cycle ticks
  reg phaseLast_q;
  reg [11:0] perCnt_q;
  reg [11:0] period_q;
  reg [11:0] sinceEdge_q;
  reg [2:0] sampleIdx_q;
  reg [11:0] nextSample_q;
  wire phaseRise = phaseClk & ~phaseLast_q;
  wire [11:0] sixth = period_q / 12'h006;
  wire sampleTick = phaseRise | (sinceEdge_q == nextSample_q && sampleIdx_q != 3'h0
    && sampleIdx_q < `SAMPLES_PER_CYCLE);
  wire halfTick = (sinceEdge_q == {1'b0, period_q[11:1]}) && !phaseRise;
  always @(posedge clock) begin
    if (!nrst) begin
      phaseLast_q <= 1'b0;
      perCnt_q <= `PER_RESET;
      period_q <= `PER_RESET;
      sinceEdge_q <= `PER_RESET;
      sampleIdx_q <= 3'h0;
      nextSample_q <= `PER_RESET;
    end else begin
      phaseLast_q <= phaseClk;
      if (phaseRise) begin
        period_q <= perCnt_q;
        perCnt_q <= 12'h001;
        sinceEdge_q <= 12'h001;
        sampleIdx_q <= 3'h1;
        nextSample_q <= sixth;
      end else begin
        if (perCnt_q != 12'hfff)
          perCnt_q <= perCnt_q + 12'h001;
        if (sinceEdge_q != 12'hfff)
          sinceEdge_q <= sinceEdge_q + 12'h001;
        if (sampleTick) begin
          sampleIdx_q <= sampleIdx_q + 3'h1;
          nextSample_q <= nextSample_q + sixth;
        end
      end
    end
  end
  // ==========================================
  // six-bit validation
  wire [5:0] validCode;
  wire validPulse;
  code_sampler sampler (
    .clock(clock),
    .nrst(nrst),
    .sampleTick(sampleTick),
    .codeIn(voltageCodeInputs),
    .validCode_q(validCode),
    .validPulse_q(validPulse)
  );
  // ==========================================
  // five-bit slewing and shutdown control
  localparam IDLE = 2'h0;
  localparam HALF = 2'h1;
  localparam SLEW = 2'h2;
  reg [1:0] state_q;
  reg [4:0] fiveCode_q;
  reg [6:0] goal_q;
  reg [1:0] offCnt_q;
  reg offPend_q;
  wire fiveMode = (codeMode != `MODE_SIX);
  // five-bit codes are read once per switching cycle, so a change waits up to one cycle
  wire fiveNew = fiveMode && phaseRise && voltageCodeInputs[4:0] != fiveCode_q;
  wire noLoadNow = fiveMode ? isNoLoad(codeMode, {1'b0, fiveCode_q})
    : isNoLoad(codeMode, validCode);
  always @(posedge clock) begin
    if (!nrst) begin
      state_q <= IDLE;
      fiveCode_q <= 5'h1f;
      goal_q <= `REF_RESET;
      refTarget_q <= `REF_RESET;
      offCnt_q <= 2'h0;
      offPend_q <= 1'b0;
      shutdownTrip_q <= 1'b1;
      pulseEnable_q <= 1'b0;
      softStartReq_q <= 1'b0;
    end else begin
      softStartReq_q <= 1'b0;
      if (!fiveMode && validPulse && !isNoLoad(codeMode, validCode))
        refTarget_q <= sixToCount(validCode);
      if (fiveNew) begin
        fiveCode_q <= voltageCodeInputs[4:0];
        // a no-load code must not drag the reference toward its table slot
        if (isNoLoad(codeMode, {1'b0, voltageCodeInputs[4:0]})) begin
          state_q <= IDLE;
        end else begin
          goal_q <= fiveToCount(voltageCodeInputs[4:0]);
          state_q <= HALF;
        end
      end else begin
        case (state_q)
          IDLE: state_q <= IDLE;
          HALF: if (halfTick) state_q <= SLEW;
          SLEW: begin
            if (refTarget_q == goal_q)
              state_q <= IDLE;
            else if (halfTick && refTarget_q < goal_q)
              refTarget_q <= refTarget_q + 7'h01;
            else if (halfTick)
              refTarget_q <= refTarget_q - 7'h01;
          end
          default: state_q <= IDLE;
        endcase
      end
      // no-load handling, delay counted in switching cycles
      if (noLoadNow && pulseEnable_q && !offPend_q) begin
        offPend_q <= 1'b1;
        offCnt_q <= 2'h0;
      end else if (offPend_q && !noLoadNow) begin
        offPend_q <= 1'b0;
      end else if (offPend_q && phaseRise) begin
        if (offCnt_q + 2'h1 == `NOLOAD_CYCLES) begin
          shutdownTrip_q <= 1'b1;
          pulseEnable_q <= 1'b0;
          offPend_q <= 1'b0;
        end
        offCnt_q <= offCnt_q + 2'h1;
      end
      if (!noLoadNow && !pulseEnable_q) begin
        pulseEnable_q <= 1'b1;
        shutdownTrip_q <= 1'b0;
        softStartReq_q <= 1'b1;
      end
    end
  end
endmodule // dynamic_vid_reference_control

// [dvid_ref_assertions.sv]
// checker for the voltage-code reference control ports
// assumes the bench phase period of 60 clocks, so six reads land 10 clocks apart
`timescale 1ns/10ps
module dvid_ref_assertions (
  input wire clock,
  input wire nrst,
  input wire phaseClk,
  input wire [1:0] codeMode,
  input wire [5:0] voltageCodeInputs,
  input wire [6:0] refTarget_q,
  input wire shutdownTrip_q,
  input wire pulseEnable_q,
  input wire softStartReq_q
);
  reg [5:0] lastCode_q;
  reg [6:0] lastRef_q;
  reg [7:0] stableCnt_q;
  reg [7:0] sinceStep_q;
  // ==========
  // helpers: saturating ages of the code and of the last reference move
  always @(posedge clock) begin
    lastCode_q <= voltageCodeInputs;
    lastRef_q <= refTarget_q;
    if (!nrst || voltageCodeInputs != lastCode_q) stableCnt_q <= 8'h00;
    else if (stableCnt_q != 8'hff) stableCnt_q <= stableCnt_q + 8'h01;
    if (!nrst) sinceStep_q <= 8'hff;
    else if (refTarget_q != lastRef_q) sinceStep_q <= 8'h00;
    else if (sinceStep_q != 8'hff) sinceStep_q <= sinceStep_q + 8'h01;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_noload;
    (codeMode == 2'h0 && voltageCodeInputs[5:1] == 5'h1f) [*4];
  endsequence
  property p_step;
    (codeMode != 2'h0 && pulseEnable_q && $changed(refTarget_q)) |->
      (refTarget_q == $past(refTarget_q) + 7'h01 || refTarget_q == $past(refTarget_q) - 7'h01);
  endproperty
  property p_space;
    (codeMode != 2'h0 && pulseEnable_q && $changed(refTarget_q)) |-> sinceStep_q >= 8'd59;
  endproperty
  property p_six;
    (codeMode == 2'h0 && pulseEnable_q && $changed(refTarget_q)) |-> $past(stableCnt_q, 2) >= 8'd16;
  endproperty
  property p_hold;
    s_noload |=> $stable(refTarget_q);
  endproperty
  property p_off;
    $fell(pulseEnable_q) |-> shutdownTrip_q;
  endproperty
  property p_delay;
    $fell(pulseEnable_q) |-> stableCnt_q >= 8'd60;
  endproperty
  property p_pulse;
    softStartReq_q |=> !softStartReq_q;
  endproperty
  property p_ssen;
    softStartReq_q |-> ##[0:2] pulseEnable_q;
  endproperty
  property p_reset;
    $rose(nrst) |-> (refTarget_q == 7'h00 && shutdownTrip_q && !pulseEnable_q && !softStartReq_q);
  endproperty
  a_step: assert property (p_step) else $error("reference moved by more than one unit");
  a_space: assert property (p_space) else $error("slew steps closer than one cycle");
  a_six: assert property (p_six) else $error("code taken before three reads");
  a_hold: assert property (p_hold) else $error("no-load code moved reference");
  a_off: assert property (p_off) else $error("pulses stopped without trip level");
  a_delay: assert property (p_delay) else $error("shutdown came too early");
  a_pulse: assert property (p_pulse) else $error("soft-start request too long");
  a_ssen: assert property (p_ssen) else $error("soft-start without pulses");
  a_reset: assert property (p_reset) else $error("wrong values out of reset");
endmodule // dvid_ref_assertions

bind dynamic_vid_reference_control dvid_ref_assertions u_chk (.clock(clock), .nrst(nrst),
  .phaseClk(phaseClk), .codeMode(codeMode), .voltageCodeInputs(voltageCodeInputs),
  .refTarget_q(refTarget_q), .shutdownTrip_q(shutdownTrip_q), .pulseEnable_q(pulseEnable_q),
  .softStartReq_q(softStartReq_q));

// [cpu_vid_model.sv]
// processor model driving the voltage code inputs
// assumes the bench raises jump to force a code at once
`timescale 1ns/10ps
module cpu_vid_model #(parameter int HOLD = 50) (
  input wire clock,
  input wire nrst,
  input wire jump,
  input wire [5:0] goal,
  output logic [5:0] code
);
  int cnt = 0;
  initial code = 6'h14;
  // ==========
  // one code step per paced transition
  always @(posedge clock) begin
    if (!nrst || jump) begin
      code <= goal;
      cnt <= 0;
    end else if (cnt == HOLD - 1) begin
      cnt <= 0;
      if (code != goal) code <= (code < goal) ? code + 6'h01 : code - 6'h01;
    end else cnt <= cnt + 1;
  end
endmodule // cpu_vid_model

// [tb_top.sv]
// self-checking bench for the voltage-code reference control
// assumes a 60-clock phase period made here
`timescale 1ns/10ps
module tb_top;
  localparam int P = 60;
  logic clock, nrst, jump;
  logic phaseClk = 1'b0;
  logic [1:0] codeMode;
  logic [5:0] goal, code;
  logic [6:0] refTarget_q;
  logic shutdownTrip_q, pulseEnable_q, softStartReq_q;
  int n_mismatch = 0;
  int num_checks = 0;
  int ph = 0;
  dynamic_vid_reference_control u_dut (.clock(clock), .nrst(nrst), .phaseClk(phaseClk),
    .codeMode(codeMode), .voltageCodeInputs(code), .refTarget_q(refTarget_q),
    .shutdownTrip_q(shutdownTrip_q), .pulseEnable_q(pulseEnable_q),
    .softStartReq_q(softStartReq_q));
  cpu_vid_model u_cpu (.clock(clock), .nrst(nrst), .jump(jump), .goal(goal), .code(code));
  initial begin clock = 0; forever #12.5 clock = ~clock; end
  always @(posedge clock) begin
    ph <= (ph == P - 1) ? 0 : ph + 1;
    phaseClk <= #1 (ph < P / 2);
  end
  // ==========
  // shared tasks
  task automatic cycles(input int n); repeat (n) @(posedge clock); #1; endtask
  task automatic chk(input logic [6:0] got, input logic [6:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin n_mismatch++; $display("unexpected at %0t: %s", $time, m); end
  endtask
  task automatic restart(input logic [1:0] md, input logic [5:0] c);
    nrst = 0; codeMode = md; goal = c; jump = 1; cycles(6); nrst = 1;
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_six;
    restart(2'h0, 6'h14); cycles(3 * P);
    chk(refTarget_q, 7'd0, "six start");
    jump = 0; goal = 6'h10; cycles(190);
    chk(refTarget_q, 7'd3, "six step");
    cycles(50);
    chk(refTarget_q, 7'd4, "six step late");
    jump = 1; goal = 6'h00; cycles(12); goal = 6'h10; cycles(P);
    chk(refTarget_q, 7'd4, "short code taken");
  endtask
  task automatic t_five(input logic [1:0] md, input logic [5:0] c, input logic [6:0] n);
    restart(md, c); cycles(32 * P);
    chk(refTarget_q, n, "five ramp");
    goal = c - 6'h04; cycles(6 * P);
    chk({6'h0, refTarget_q < n + 7'd8}, 7'h01, "slew too fast");
    cycles(5 * P);
    chk(refTarget_q, n + 7'd8, "multi step");
  endtask
  task automatic t_noload(input logic [1:0] md, input logic [5:0] nl, input logic [5:0] ok);
    logic [6:0] r;
    int i;
    restart(md, ok); cycles(32 * P); r = refTarget_q;
    goal = nl; cycles(P / 2);
    chk({6'h0, pulseEnable_q}, 7'h01, "early off");
    cycles(4 * P);
    chk({5'h0, shutdownTrip_q, pulseEnable_q}, 7'h02, "not off");
    chk(refTarget_q, r, "ref moved");
    goal = ok;
    for (i = 0; i < 3 * P && softStartReq_q !== 1'b1; i++) cycles(1);
    chk({6'h0, softStartReq_q}, 7'h01, "no soft start");
  endtask
  initial begin
    nrst = 0; codeMode = 2'h0; goal = 6'h14; jump = 1;
    t_six;
    t_five(2'h1, 6'h1e, 7'd21);
    t_five(2'h2, 6'h1c, 7'd25);
    t_noload(2'h0, 6'h3f, 6'h14);
    t_noload(2'h0, 6'h3e, 6'h14);
    t_noload(2'h1, 6'h1f, 6'h1e);
    report_and_stop;
  end
  initial begin repeat (20000) @(posedge clock); n_mismatch++; report_and_stop; end
endmodule // tb_top
